// file: hw/crc_consts.vh
// Constants for the programmable CRC generator
`ifndef CRC_CONSTS_VH
`define CRC_CONSTS_VH

// Register byte offsets
`define CRC_OFF_CONTROL     4'h0
`define CRC_OFF_POLY_TAP    4'h4
`define CRC_OFF_WRITE_DATA  4'h8
`define CRC_OFF_DATA_INPUT  4'hC

// Control register field positions
`define CRC_POLY_LENGTH_MINUS_ONE_LSB        0
`define CRC_POLY_LENGTH_MINUS_ONE_MSB        3
`define CRC_GO_BIT          4
`define CRC_EMPTY_BIT       6
`define CRC_FULL_BIT        7
`define CRC_COUNT_LSB       8
`define CRC_COUNT_MSB       12
`define CRC_IDLE_STOP_BIT   13

// Reset values
`define CRC_POLY_LENGTH_MINUS_ONE_RST        4'h0
`define CRC_COUNT_RST       5'h00
`define CRC_TAPS_RST        15'h0000
`define CRC_WORD_RST        16'h0000

// FIFO depth selection
`define CRC_POLY_LENGTH_MINUS_ONE_SHORT_MAX  4'h7
`define CRC_DEPTH_LONG      5'h08
`define CRC_DEPTH_SHORT     5'h10
`define CRC_POLY_LENGTH_MINUS_ONE_TOP        4'hF

`endif

// file: hw/crc_generator.v
// Programmable CRC generator with word FIFO and Avalon-MM register slave
// Summary of operation
// (R1) Per-term enables 15..1, 4-bit length field
// (R2) Constant term always fed back
// (R3) FIFO depth 8 when length field above 7, else 16
// (R4) Word width is length field plus one bits
// (R5) Write of top byte bumps word count
// (R6) Go with words pending feeds the engine
// (R7) Engine takes half-length cycles per word
// (R8) Full at depth, empty at zero
// (R9) Write while full wraps count, no event
// (R10) Software waits a cycle before count read
// (R11) Event when count falls one to zero
// (R12) Software reads result only once empty
// (R13) Software flushes FIFO by running go
// (R14) Software primes FIFO then polls count
// (R15) Sleep freezes whole engine state; a data-input seed write still loads the idle engine while asleep
// (R16) Idle stop freezes like sleep, events pass
// (R17) Go bit starts and stops the shifter
// (R18) Length field is length minus one
// (R19) Read-only count field in control 12:8
// (R20) Tap bit zero reads zero
// (R21) Serial LFSR, msb first, remainder readable
// (R22) Reset clears control, empty flag set
`timescale 1ns/1ps
`include "crc_consts.vh"

module crc_generator #(
    parameter W     = 16,
    parameter DEPTH = 16
) (
    // Clock and reset
    input  wire        i_clk,
    input  wire        i_nrst,
    // Avalon-MM slave
    input  wire [3:0]  i_avs_address,
    input  wire        i_avs_read,
    input  wire        i_avs_write,
    input  wire [31:0] i_avs_writedata,
    input  wire [3:0]  i_avs_byteenable,
    output reg  [31:0] o_avs_readdata,
    output wire        o_avs_waitrequest,
    // Power modes
    input  wire        i_sleep,
    input  wire        i_idle,
    // Event to the interrupt controller
    output reg         o_crc_event,
    // Status
    output wire        o_fifo_full_flag,
    output wire        o_fifo_empty_flag
);

////////////////////////////////////////////////////////////////////////////
// Registers and nets

reg  [3:0]   poly_length_minus_one_q;
reg          shift_go_q;
reg          idle_stop_q;
reg  [15:1]  poly_taps_q;
reg  [4:0]   fifo_word_count_q;
reg  [4:0]   fifo_word_count_d;
reg  [3:0]   wr_ptr_q;
reg  [3:0]   wr_ptr_d;
reg  [3:0]   rd_ptr_q;
reg  [3:0]   rd_ptr_d;
reg  [W-1:0] fifo_mem_q [0:DEPTH-1];
reg  [15:0]  hold_q;
reg          ack_q;

wire         req;
wire         bus_wr;
wire         bus_rd;
wire         sel_ctrl;
wire         sel_poly;
wire         sel_wdat;
wire         sel_dinp;
wire [15:0]  hold_merged;
wire [W-1:0] word_mask;
wire [W-1:0] push_word;
wire         top_lane_hit;
wire         push;
wire         wrap;
wire         pop;
wire [4:0]   depth_now;
wire         frozen;
wire         eng_ready;
wire         eng_busy;
wire [W-1:0] eng_crc;
wire [15:0]  ctrl_view;
wire [15:0]  poly_view;

////////////////////////////////////////////////////////////////////////////
// Bus decode, one wait state on every access

assign req      = i_avs_read | i_avs_write;
assign o_avs_waitrequest = req & ~ack_q;
assign bus_wr   = i_avs_write & ack_q;
assign bus_rd   = i_avs_read & ~ack_q;
assign sel_ctrl = (i_avs_address == `CRC_OFF_CONTROL);
assign sel_poly = (i_avs_address == `CRC_OFF_POLY_TAP);
assign sel_wdat = (i_avs_address == `CRC_OFF_WRITE_DATA);
assign sel_dinp = (i_avs_address == `CRC_OFF_DATA_INPUT);

always @(posedge i_clk) begin
    if (!i_nrst) begin
        ack_q <= 1'b0;
    end else begin
        ack_q <= req & ~ack_q;
    end
end

////////////////////////////////////////////////////////////////////////////
// Power-save freeze

// (R15) sleep holds state
// (R16) idle stop option
assign frozen = i_sleep | (i_idle & idle_stop_q);

////////////////////////////////////////////////////////////////////////////
// Control and tap registers

// (R22) reset values
always @(posedge i_clk) begin
    if (!i_nrst) begin
        poly_length_minus_one_q <= `CRC_POLY_LENGTH_MINUS_ONE_RST;
        shift_go_q              <= 1'b0;
        idle_stop_q             <= 1'b0;
        poly_taps_q             <= `CRC_TAPS_RST;
    end else if (bus_wr) begin
        if (sel_ctrl && i_avs_byteenable[0]) begin
            // (R18) length minus one
            poly_length_minus_one_q <=
                i_avs_writedata[`CRC_POLY_LENGTH_MINUS_ONE_MSB:`CRC_POLY_LENGTH_MINUS_ONE_LSB];
            // (R17) go on or off
            shift_go_q <= i_avs_writedata[`CRC_GO_BIT];
        end
        if (sel_ctrl && i_avs_byteenable[1]) begin
            idle_stop_q <= i_avs_writedata[`CRC_IDLE_STOP_BIT];
        end
        // (R1) per-term enables
        if (sel_poly && i_avs_byteenable[0]) begin
            poly_taps_q[7:1] <= i_avs_writedata[7:1];
        end
        if (sel_poly && i_avs_byteenable[1]) begin
            poly_taps_q[15:8] <= i_avs_writedata[15:8];
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// Write staging: a word may arrive one byte at a time

assign hold_merged = {
    i_avs_byteenable[1] ? i_avs_writedata[15:8] : hold_q[15:8],
    i_avs_byteenable[0] ? i_avs_writedata[7:0]  : hold_q[7:0]
};

// (R4) drop bits above width
assign word_mask = ~({W{1'b1}} << ({1'b0, poly_length_minus_one_q} + 5'h01));
assign push_word = hold_merged[W-1:0] & word_mask;

// (R5) top lane completes word
assign top_lane_hit = (poly_length_minus_one_q > `CRC_POLY_LENGTH_MINUS_ONE_SHORT_MAX) ?
                      i_avs_byteenable[1] : i_avs_byteenable[0];

assign push = bus_wr & sel_wdat & top_lane_hit;

always @(posedge i_clk) begin
    if (!i_nrst) begin
        hold_q <= `CRC_WORD_RST;
    end else if (bus_wr && sel_wdat) begin
        hold_q <= hold_merged;
    end
end

////////////////////////////////////////////////////////////////////////////
// FIFO occupancy

// (R3) depth from length
assign depth_now = (poly_length_minus_one_q > `CRC_POLY_LENGTH_MINUS_ONE_SHORT_MAX) ?
                   `CRC_DEPTH_LONG : `CRC_DEPTH_SHORT;

// (R8) full and empty flags
assign o_fifo_full_flag  = (fifo_word_count_q == depth_now);
assign o_fifo_empty_flag = (fifo_word_count_q == 5'h00);

// (R9) overrun wraps to empty
assign wrap = push & o_fifo_full_flag;

// (R6) drain while go set
assign pop = shift_go_q & ~o_fifo_empty_flag & eng_ready & ~frozen & ~wrap;

always @* begin
    fifo_word_count_d = fifo_word_count_q;
    wr_ptr_d          = wr_ptr_q;
    rd_ptr_d          = rd_ptr_q;
    if (wrap) begin
        // Overrun word is lost; pointers restart together
        fifo_word_count_d = 5'h00;
        wr_ptr_d          = 4'h0;
        rd_ptr_d          = 4'h0;
    end else begin
        if (push) begin
            wr_ptr_d = wr_ptr_q + 4'h1;
        end
        if (pop) begin
            rd_ptr_d = rd_ptr_q + 4'h1;
        end
        if (push && !pop) begin
            fifo_word_count_d = fifo_word_count_q + 5'h01;
        end else if (pop && !push) begin
            fifo_word_count_d = fifo_word_count_q - 5'h01;
        end
    end
end

always @(posedge i_clk) begin
    if (!i_nrst) begin
        fifo_word_count_q <= `CRC_COUNT_RST;
        wr_ptr_q          <= 4'h0;
        rd_ptr_q          <= 4'h0;
    end else begin
        fifo_word_count_q <= fifo_word_count_d;
        wr_ptr_q          <= wr_ptr_d;
        rd_ptr_q          <= rd_ptr_d;
    end
end

////////////////////////////////////////////////////////////////////////////
// FIFO storage, one entry per generate slot

genvar gi;
generate
    for (gi = 0; gi < DEPTH; gi = gi + 1) begin : g_entry
        always @(posedge i_clk) begin
            if (!i_nrst) begin
                fifo_mem_q[gi] <= {W{1'b0}};
            end else if (push && !wrap && wr_ptr_q == gi) begin
                fifo_mem_q[gi] <= push_word;
            end
        end
    end
endgenerate

////////////////////////////////////////////////////////////////////////////
// Completion event

// (R11) count one to zero
// Wrap never raises it; pulse still passes while frozen
always @(posedge i_clk) begin
    if (!i_nrst) begin
        o_crc_event <= 1'b0;
    end else begin
        o_crc_event <= pop && !push && (fifo_word_count_q == 5'h01);
    end
end

////////////////////////////////////////////////////////////////////////////
// Shift engine

crc_shift_engine #(
    .W (W)
) u_engine (
    .i_clk     (i_clk),
    .i_nrst    (i_nrst),
    .i_run     (~frozen),
    .i_load    (pop),
    .i_word    (fifo_mem_q[rd_ptr_q]),
    .i_seed_we (bus_wr & sel_dinp),
    .i_seed    (i_avs_writedata[W-1:0]),
    .i_poly_length_minus_one    (poly_length_minus_one_q),
    .i_taps    (poly_taps_q),
    .o_ready   (eng_ready),
    .o_busy    (eng_busy),
    .o_crc     (eng_crc)
);

////////////////////////////////////////////////////////////////////////////
// Read path

// (R19) count field view
assign ctrl_view = {
    2'b00,
    idle_stop_q,
    fifo_word_count_q,
    o_fifo_full_flag,
    o_fifo_empty_flag,
    1'b0,
    shift_go_q,
    poly_length_minus_one_q
};

// (R20) tap bit zero reads zero
assign poly_view = {poly_taps_q, 1'b0};

// Read data is captured in the wait cycle and stands while ack is high
always @(posedge i_clk) begin
    if (!i_nrst) begin
        o_avs_readdata <= 32'h00000000;
    end else if (bus_rd) begin
        if (sel_ctrl) begin
            o_avs_readdata <= {16'h0000, ctrl_view};
        end else if (sel_poly) begin
            o_avs_readdata <= {16'h0000, poly_view};
        end else if (sel_wdat || sel_dinp) begin
            // (R21) remainder readable
            o_avs_readdata <= {{(32-W){1'b0}}, eng_crc};
        end else begin
            o_avs_readdata <= 32'h00000000;
        end
    end
end

endmodule

// file: hw/crc_shift_engine.v
// Two-bit-per-clock linear feedback shift engine for the CRC generator
`timescale 1ns/1ps
`include "crc_consts.vh"

module crc_shift_engine #(
    parameter W = 16
) (
    // Clock and reset
    input  wire         i_clk,
    input  wire         i_nrst,
    // Control
    input  wire         i_run,
    input  wire         i_load,
    input  wire [W-1:0] i_word,
    input  wire         i_seed_we,
    input  wire [W-1:0] i_seed,
    input  wire [3:0]   i_poly_length_minus_one,
    input  wire [15:1]  i_taps,
    // Status and result
    output wire         o_ready,
    output wire         o_busy,
    output wire [W-1:0] o_crc
);

reg  [W-1:0] data_q;
reg  [4:0]   left_q;
reg  [W-1:0] crc_q;
wire [W-1:0] mask;
wire [W-1:0] taps;
wire [W-1:0] crc_one;
wire [W-1:0] crc_two;

function [W-1:0] lfsr_step;
    input [W-1:0] c;
    input         b;
    input [W-1:0] t;
    input [W-1:0] m;
    input [3:0]   p;
    reg           fb;
    begin
        fb = b ^ c[p];
        lfsr_step = ({c[W-2:0], 1'b0} ^ (fb ? t : {W{1'b0}})) & m;
    end
endfunction

////////////////////////////////////////////////////////////////////////////
// (R2) constant term fixed on
assign taps    = {i_taps, 1'b1};
// Top term of the polynomial is implied by the shift out of bit poly_length_minus_one
assign mask    = ~({W{1'b1}} << ({1'b0, i_poly_length_minus_one} + 5'h01));
// (R21) msb first feedback
assign crc_one = lfsr_step(crc_q, data_q[W-1], taps, mask, i_poly_length_minus_one);
assign crc_two = lfsr_step(crc_one, data_q[W-2], taps, mask, i_poly_length_minus_one);

// Next word may load in the cycle the last bits leave
assign o_ready = (left_q == 5'h00) || (i_run && (left_q <= 5'h02));
assign o_busy  = (left_q != 5'h00);
assign o_crc   = crc_q;

////////////////////////////////////////////////////////////////////////////
always @(posedge i_clk) begin
    if (!i_nrst) begin
        data_q <= `CRC_WORD_RST;
        left_q <= 5'h00;
        crc_q  <= `CRC_WORD_RST;
    end else begin
        if (i_seed_we && !o_busy) begin
            crc_q <= i_seed & mask;
        end else if (i_run && left_q != 5'h00) begin
            // (R7) two bits per clock
            crc_q  <= (left_q >= 5'h02) ? crc_two : crc_one;
            data_q <= data_q << 2;
            left_q <= (left_q >= 5'h02) ? left_q - 5'h02 : 5'h00;
        end
        if (i_load) begin
            data_q <= i_word << (`CRC_POLY_LENGTH_MINUS_ONE_TOP - i_poly_length_minus_one);
            left_q <= {1'b0, i_poly_length_minus_one} + 5'h01;
        end
    end
end

endmodule

// file: test/crc_generator_asserts.sv
// Port-level checks for the CRC generator
`timescale 1ns/1ps
module crc_generator_asserts (
    // Clock and reset
    input wire        i_clk,
    input wire        i_nrst,
    // Register bus
    input wire [3:0]  i_avs_address,
    input wire        i_avs_read,
    input wire        i_avs_write,
    input wire [31:0] i_avs_writedata,
    input wire [3:0]  i_avs_byteenable,
    input wire [31:0] o_avs_readdata,
    input wire        o_avs_waitrequest,
    // Power modes and status
    input wire        i_sleep,
    input wire        i_idle,
    input wire        o_crc_event,
    input wire        o_fifo_full_flag,
    input wire        o_fifo_empty_flag
);
    wire req = i_avs_read | i_avs_write;
    ////////////////////////////////////////////////////////////
    a_wait_first: assert property (@(posedge i_clk) disable iff (!i_nrst)
        $rose(req) |-> o_avs_waitrequest) else $error("no wait state");
    a_wait_one: assert property (@(posedge i_clk) disable iff (!i_nrst)
        req && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("wait state too long");
    a_flags_excl: assert property (@(posedge i_clk) disable iff (!i_nrst)
        !(o_fifo_full_flag && o_fifo_empty_flag)) else $error("full and empty");
    a_event_pulse: assert property (@(posedge i_clk) disable iff (!i_nrst)
        o_crc_event |=> !o_crc_event) else $error("event too long");
    a_event_cause: assert property (@(posedge i_clk) disable iff (!i_nrst)
        o_crc_event |-> $past(!o_fifo_empty_flag) ||
        $past(!o_fifo_empty_flag, 2)) else $error("event without drain");
    a_sleep_hold: assert property (@(posedge i_clk) disable iff (!i_nrst)
        $past(i_sleep) && !$past(i_avs_write) |-> !$rose(o_fifo_empty_flag))
        else $error("drained while asleep");
    a_full_cause: assert property (@(posedge i_clk) disable iff (!i_nrst)
        $rose(o_fifo_full_flag) |-> $past(i_avs_write))
        else $error("full without write");
    a_empty_fall: assert property (@(posedge i_clk) disable iff (!i_nrst)
        $fell(o_fifo_empty_flag) |-> $past(i_avs_write))
        else $error("count rose without write");
    a_read_upper: assert property (@(posedge i_clk) disable iff (!i_nrst)
        i_avs_read && !o_avs_waitrequest |-> o_avs_readdata[31:16] == 16'h0000)
        else $error("upper read bits set");
    a_read_unmapped: assert property (@(posedge i_clk) disable iff (!i_nrst)
        i_avs_read && !o_avs_waitrequest && i_avs_address[1:0] != 2'b00
        |-> o_avs_readdata == 32'h00000000) else $error("unmapped read");
    a_reset_flags: assert property (@(posedge i_clk)
        !i_nrst |=> o_fifo_empty_flag && !o_fifo_full_flag && !o_crc_event)
        else $error("bad flags after reset");
endmodule

bind crc_generator crc_generator_asserts i_chk (.i_clk, .i_nrst,
    .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
    .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .i_sleep,
    .i_idle, .o_crc_event, .o_fifo_full_flag, .o_fifo_empty_flag);

// file: test/test_crc_generator.sv
// Self-checking bench for the CRC generator
`timescale 1ns/1ps
module test_crc_generator;
    logic        i_clk, i_nrst, i_avs_read, i_avs_write, i_sleep, i_idle;
    logic [3:0]  i_avs_address, i_avs_byteenable;
    logic [31:0] i_avs_writedata, rd;
    wire  [31:0] o_avs_readdata;
    wire         o_avs_waitrequest, o_crc_event;
    wire         o_fifo_full_flag, o_fifo_empty_flag;
    int          num_errors = 0, n_checks = 0, nev = 0, cyc = 0, ev0;
    logic [15:0] exp_crc;
    // Rows: length, taps, seed, data, words
    logic [3:0]  pl [5] = '{4'hF, 4'h7, 4'h5, 4'h8, 4'h0};
    logic [15:0] tp [5] = '{16'h1021, 16'h0007, 16'h0003, 16'h0131, 16'h0};
    logic [15:0] sd [5] = '{16'h0000, 16'h00FF, 16'hFFFF, 16'h0000, 16'h0};
    logic [15:0] dt [5] = '{16'hABCD, 16'h005A, 16'h00FF, 16'h01A5, 16'h1};
    int          nw [5] = '{1, 2, 1, 2, 3};

    crc_generator i_crc_generator (.i_clk, .i_nrst, .i_avs_address,
        .i_avs_read, .i_avs_write, .i_avs_writedata, .i_avs_byteenable,
        .o_avs_readdata, .o_avs_waitrequest, .i_sleep, .i_idle,
        .o_crc_event, .o_fifo_full_flag, .o_fifo_empty_flag);

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    // Hang guard well above the expected run length
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (o_crc_event === 1'b1)
            nev <= nev + 1;
        if (cyc == 20000) begin
            num_errors++;
            results();
        end
    end
    ////////////////////////////////////////////////////////////
    task results;
        $display("errors %0d checks %0d", num_errors, n_checks);
        if (num_errors == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask
    task bus(input logic w, input logic [3:0] a, input logic [15:0] d);
        @(posedge i_clk);
        i_avs_write <= w;
        i_avs_read <= !w;
        i_avs_address <= a;
        i_avs_writedata <= {16'h0000, d};
        do @(posedge i_clk); while (o_avs_waitrequest !== 1'b0);
        rd = o_avs_readdata;
        i_avs_write <= 1'b0;
        i_avs_read <= 1'b0;
    endtask
    task rchk(input string nm, input logic [3:0] a, input logic [15:0] e);
        bus(1'b0, a, 16'h0000);
        chk(nm, {16'h0000, e}, rd);
    endtask
    task push(input int n, input logic [15:0] d);
        repeat (n) bus(1'b1, 4'h8, d);
    endtask
    // Result settles half a word length after the event
    task wait_ev(input logic [3:0] p);
        int n0;
        n0 = nev;
        repeat (300) if (nev == n0) @(posedge i_clk);
        chk("event", n0 + 1, nev);
        repeat (p / 2 + 3) @(posedge i_clk);
    endtask
    function logic [15:0] crcm(input logic [15:0] c, input logic [15:0] d,
                               input logic [3:0] p, input logic [15:0] t);
        logic [16:0] m;
        m = (17'h00001 << (p + 1)) - 17'h00001;
        c = c & m[15:0];
        for (int i = 15; i >= 0; i--)
            if (i <= p)
                c = ({c[14:0], 1'b0} ^ ((d[i] ^ c[p]) ? (t | 16'h0001)
                    : 16'h0000)) & m[15:0];
        return c;
    endfunction
    ////////////////////////////////////////////////////////////
    initial begin
        i_nrst = 1'b0;
        i_avs_read = 1'b0;
        i_avs_write = 1'b0;
        i_avs_address = 4'h0;
        i_avs_writedata = 32'h00000000;
        i_avs_byteenable = 4'h3;
        i_sleep = 1'b0;
        i_idle = 1'b0;
        repeat (20) @(posedge i_clk);
        i_nrst <= 1'b1;
        rchk("ctrl rst", 4'h0, 16'h0040);
        rchk("taps rst", 4'h4, 16'h0000);
        bus(1'b1, 4'h4, 16'hFFFF);
        rchk("taps", 4'h4, 16'hFFFE);
        bus(1'b1, 4'h0, 16'hFFFF);
        rchk("ctrl rw", 4'h0, 16'h205F);
        rchk("unmapped", 4'h2, 16'h0000);
        for (int r = 0; r < 5; r++) begin
            bus(1'b1, 4'h0, {12'h000, pl[r]});
            bus(1'b1, 4'h4, tp[r]);
            bus(1'b1, 4'hC, sd[r]);
            push(nw[r], dt[r]);
            rchk("count", 4'h0, {3'b000, nw[r][4:0], 4'h0, pl[r]});
            exp_crc = sd[r];
            repeat (nw[r]) exp_crc = crcm(exp_crc, dt[r], pl[r], tp[r]);
            bus(1'b1, 4'h0, {12'h001, pl[r]});
            wait_ev(pl[r]);
            chk("empty pin", 32'h1, {31'h0, o_fifo_empty_flag});
            rchk("crc", 4'h8, exp_crc);
            rchk("done", 4'h0, {12'h005, pl[r]});
        end
        // Wide word arriving one byte lane at a time
        bus(1'b1, 4'h0, 16'h000F);
        bus(1'b1, 4'hC, 16'h0000);
        i_avs_byteenable <= 4'h1;
        bus(1'b1, 4'h8, 16'h00CD);
        rchk("lane0 only", 4'h0, 16'h004F);
        i_avs_byteenable <= 4'h2;
        bus(1'b1, 4'h8, 16'hAB00);
        i_avs_byteenable <= 4'h3;
        rchk("lane1 push", 4'h0, 16'h010F);
        exp_crc = crcm(16'h0000, 16'hABCD, 4'hF, 16'h0000);
        bus(1'b1, 4'h0, 16'h001F);
        wait_ev(4'hF);
        rchk("staged crc", 4'h8, exp_crc);
        bus(1'b1, 4'h0, 16'h0007);
        push(16, 16'h0011);
        rchk("full16", 4'h0, 16'h1087);
        chk("full pin", 32'h1, {31'h0, o_fifo_full_flag});
        ev0 = nev;
        push(1, 16'h0011);
        rchk("wrap", 4'h0, 16'h0047);
        bus(1'b1, 4'h0, 16'h0017);
        repeat (30) @(posedge i_clk);
        chk("no event", ev0, nev);
        bus(1'b1, 4'h0, 16'h000F);
        push(8, 16'h1234);
        rchk("full8", 4'h0, 16'h088F);
        i_sleep <= 1'b1;
        bus(1'b1, 4'h0, 16'h001F);
        repeat (20) @(posedge i_clk);
        rchk("sleep", 4'h0, 16'h089F);
        i_sleep <= 1'b0;
        wait_ev(4'hF);
        rchk("flushed", 4'h0, 16'h005F);
        i_idle <= 1'b1;
        bus(1'b1, 4'h0, 16'h200F);
        push(1, 16'h00AA);
        bus(1'b1, 4'h0, 16'h201F);
        repeat (20) @(posedge i_clk);
        rchk("idle stop", 4'h0, 16'h211F);
        bus(1'b1, 4'h0, 16'h001F);
        wait_ev(4'hF);
        i_idle <= 1'b0;
        results();
    end
endmodule
